// >>> core/istp_params.svh
`ifndef ISTP_PARAMS_SVH
`define ISTP_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ISTP_OFF_CTRL      12'h000
`define ISTP_OFF_CFG       12'h004
`define ISTP_OFF_STATUS    12'h008
`define ISTP_OFF_IRQ_STAT  12'h00c
`define ISTP_OFF_IRQ_CLR   12'h010
`define ISTP_OFF_IRQ_EN    12'h014
`define ISTP_OFF_DATA      12'h018

// ----------------------------------------------------------------
// bus_control_register fields
// ----------------------------------------------------------------
`define ISTP_CTRL_STOP     0
`define ISTP_CTRL_START    1
`define ISTP_CTRL_ACKE     2
`define ISTP_CTRL_WTIM     3
`define ISTP_CTRL_WREL     5
`define ISTP_CTRL_OPEN     7
`define ISTP_CTRL_RW_MASK  8'h8c
`define ISTP_CTRL_RST      8'h00

// ----------------------------------------------------------------
// configuration, status and interrupt fields
// ----------------------------------------------------------------
`define ISTP_CFG_RSVDIS    0
`define ISTP_CFG_RST       8'h00
`define ISTP_ST_MASTER     0
`define ISTP_ST_WAIT       1
`define ISTP_ST_BUSY       2
`define ISTP_ST_FIRSTSTOP  3
`define ISTP_ST_RSVPEND    4
`define ISTP_EV_DONE       0
`define ISTP_EV_BUSSTOP    1
`define ISTP_EV_REFUSE     2
`define ISTP_EV_NINTH      3
`define ISTP_IRQ_RST       4'h0
`define ISTP_DATA_RST      8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ISTP_CLK_MHZ       50
`define ISTP_T_SETUP_NS    4700
`define ISTP_T_HOLD_NS     4000
`define ISTP_SETUP_CYC     ((`ISTP_T_SETUP_NS*`ISTP_CLK_MHZ+999)/1000)
`define ISTP_HOLD_CYC      ((`ISTP_T_HOLD_NS*`ISTP_CLK_MHZ+999)/1000)

`endif

// >>> core/istp_pkg.sv
package istp_pkg;

  // ----------------------------------------------------------------
  // stop sequencer states, gray along the path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_SDA_LOW = 3'h1,
    ST_SCL_REL = 3'h3,
    ST_HOLD    = 3'h2,
    ST_SDA_REL = 3'h6
  } istp_state_type;

endpackage

// >>> core/istp_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser for a pin level
module istp_sync (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic rst_val_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    nxt_meta = d_i;
    nxt_sync = meta_ff;
  end

  // first stage feeds only the second stage
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta_ff <= rst_val_i;
      sync_ff <= rst_val_i;
    end else if (ce_i) begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign q_o = sync_ff;

endmodule

// >>> core/istp_top.sv
`timescale 1ns/1ps
`include "istp_params.svh"

// Summary of operation
// R1: writing stop_trigger 1 issues a stop; writing 0 does nothing.
// R2: hold data low, release clock until high, wait hold, release data.
// R3: in master reception set stop only with ack off, in final wait.
// R4: in master transmission set stop only during the wait period.
// R5: software never writes stop and start triggers together.
// R6: a stop trigger set is accepted only while acting as bus master.
// R7: with reservation on, software issues one stop before first bus stop.
// R8: wait_timing_select 0 after eight clocks: stop in ninth clock high.
// R9: for ninth-clock ack, switch timing, release wait, stop after ninth.
// R10: while stop_trigger is 1, further writes of 1 are ignored.
// R11: stop_trigger always reads back as 0.
// R12: reservation_disable 0 enables reservation, 1 disables it.
// R13: stop_trigger clears after the stop, on disable and at reset.
// R14: an accepted stop trigger also releases a pending wait.
module istp_top (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        master_i,
  input  wire logic        wait_i,
  input  wire logic        wait8_i,
  output logic             wait_release_o,
  output logic             start_req_o,
  output logic             ack_enable_o,
  output logic             wait_timing_o,
  output logic             reservation_en_o,
  output logic             stop_busy_o,
  output logic             irq_o
);

  localparam logic [8:0] SETUP_CYC = 9'(`ISTP_SETUP_CYC);
  localparam logic [8:0] HOLD_CYC  = 9'(`ISTP_HOLD_CYC);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  istp_pkg::istp_state_type st_ff, nxt_st;
  logic [7:0]  ctrl_ff, nxt_ctrl;
  logic [7:0]  cfg_ff, nxt_cfg;
  logic [7:0]  data_ff, nxt_data;
  logic [3:0]  irq_stat_ff, nxt_irq_stat;
  logic [3:0]  irq_en_ff, nxt_irq_en;
  logic [8:0]  cnt_ff, nxt_cnt;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        trig_ff, nxt_trig;
  logic        ninth_ff, nxt_ninth;
  logic        first_stop_ff, nxt_first_stop;
  logic        wrel_ff, nxt_wrel;
  logic        start_ff, nxt_start;
  logic        loaded_ff, nxt_loaded;
  logic        sda_q_ff, nxt_sda_q;
  logic        scl_s, sda_s;
  logic        access, wr, hit;
  logic        wr_ctrl, set_req, both_req, accept, refuse, bus_stop;
  logic [7:0]  wdata;
  logic [3:0]  ev;
  logic [31:0] rdata;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  istp_sync u_scl_sync (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .rst_val_i (1'b1),
    .d_i       (scl_i),
    .q_o       (scl_s)
  );

  istp_sync u_sda_sync (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .rst_val_i (1'b1),
    .d_i       (sda_i),
    .q_o       (sda_s)
  );

  // ----------------------------------------------------------------
  // apb decode and read mux
  // ----------------------------------------------------------------
  always_comb begin
    access = psel_i & penable_i;
    wr     = access & pwrite_i & pready_o & pstrb_i[0];
    wdata  = pwdata_i[7:0];
    hit    = (paddr_i == `ISTP_OFF_CTRL)     |
             (paddr_i == `ISTP_OFF_CFG)      |
             (paddr_i == `ISTP_OFF_STATUS)   |
             (paddr_i == `ISTP_OFF_IRQ_STAT) |
             (paddr_i == `ISTP_OFF_IRQ_CLR)  |
             (paddr_i == `ISTP_OFF_IRQ_EN)   |
             (paddr_i == `ISTP_OFF_DATA);
    rdata  = 32'h0000_0000;
    case (paddr_i)
      `ISTP_OFF_CTRL:     rdata[7:0] = ctrl_ff & `ISTP_CTRL_RW_MASK; // R11
      `ISTP_OFF_CFG:      rdata[7:0] = cfg_ff;
      `ISTP_OFF_STATUS: begin
        rdata[`ISTP_ST_MASTER]    = master_i;
        rdata[`ISTP_ST_WAIT]      = wait_i;
        rdata[`ISTP_ST_BUSY]      = trig_ff;
        rdata[`ISTP_ST_FIRSTSTOP] = first_stop_ff;
        rdata[`ISTP_ST_RSVPEND]   = reservation_en_o &
                                    ctrl_ff[`ISTP_CTRL_OPEN] &
                                    ~first_stop_ff; // R7
      end
      `ISTP_OFF_IRQ_STAT: rdata[3:0] = irq_stat_ff;
      `ISTP_OFF_IRQ_EN:   rdata[3:0] = irq_en_ff;
      `ISTP_OFF_DATA:     rdata[7:0] = data_ff;
      default:            rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // trigger acceptance and bus stop detection
  // ----------------------------------------------------------------
  always_comb begin
    wr_ctrl  = wr & (paddr_i == `ISTP_OFF_CTRL);
    set_req  = wr_ctrl & wdata[`ISTP_CTRL_STOP];                  // R1
    both_req = set_req & wdata[`ISTP_CTRL_START];                 // R5
    accept   = set_req & ~both_req & master_i & ~trig_ff &        // R6 R10
               wdata[`ISTP_CTRL_OPEN];
    refuse   = set_req & ~accept;
    bus_stop = ~sda_q_ff & sda_s & scl_s;
    ev       = 4'h0;
    ev[`ISTP_EV_BUSSTOP] = bus_stop;
    ev[`ISTP_EV_REFUSE]  = refuse;
    ev[`ISTP_EV_DONE]    = (st_ff == istp_pkg::ST_SDA_REL);
    ev[`ISTP_EV_NINTH]   = (st_ff == istp_pkg::ST_SDA_REL) & ninth_ff;
  end

  // ----------------------------------------------------------------
  // register and sequencer next values
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl       = ctrl_ff;
    nxt_cfg        = cfg_ff;
    nxt_data       = data_ff;
    nxt_irq_en     = irq_en_ff;
    nxt_st         = st_ff;
    nxt_cnt        = cnt_ff;
    nxt_trig       = trig_ff;
    nxt_ninth      = ninth_ff;
    nxt_first_stop = first_stop_ff | bus_stop;
    nxt_sda_q      = sda_s;
    nxt_loaded     = psel_i & ~(penable_i & pready_o);
    nxt_prdata     = psel_i ? rdata : prdata_ff;
    nxt_start      = wr_ctrl & wdata[`ISTP_CTRL_START] &
                     ~wdata[`ISTP_CTRL_STOP];
    nxt_wrel       = accept |                                     // R14
                     (wr_ctrl & wdata[`ISTP_CTRL_WREL]) |         // R9
                     (wr & (paddr_i == `ISTP_OFF_DATA));
    // set wins over clear
    nxt_irq_stat   = irq_stat_ff | ev;
    if (wr) begin
      case (paddr_i)
        `ISTP_OFF_CTRL:    nxt_ctrl   = wdata & `ISTP_CTRL_RW_MASK;
        `ISTP_OFF_CFG:     nxt_cfg    = wdata;
        `ISTP_OFF_IRQ_CLR: nxt_irq_stat = (irq_stat_ff & ~wdata[3:0]) | ev;
        `ISTP_OFF_IRQ_EN:  nxt_irq_en = wdata[3:0];
        `ISTP_OFF_DATA:    nxt_data   = wdata;
        default:           nxt_data   = data_ff;
      endcase
    end
    // stop sequence
    case (st_ff)
      istp_pkg::ST_IDLE: begin
        if (accept) begin
          nxt_trig  = 1'b1;
          nxt_st    = istp_pkg::ST_SDA_LOW;
          nxt_cnt   = SETUP_CYC;
          nxt_ninth = ~ctrl_ff[`ISTP_CTRL_WTIM] & wait8_i;        // R8
        end
      end
      istp_pkg::ST_SDA_LOW: begin
        if (cnt_ff == 9'h000) begin
          nxt_st = istp_pkg::ST_SCL_REL;                          // R2
        end else begin
          nxt_cnt = cnt_ff - 9'h001;
        end
      end
      istp_pkg::ST_SCL_REL: begin
        if (scl_s) begin
          nxt_st  = istp_pkg::ST_HOLD;                            // R2
          nxt_cnt = HOLD_CYC;
        end
      end
      istp_pkg::ST_HOLD: begin
        if (cnt_ff == 9'h000) begin
          nxt_st = istp_pkg::ST_SDA_REL;                          // R2
        end else begin
          nxt_cnt = cnt_ff - 9'h001;
        end
      end
      istp_pkg::ST_SDA_REL: begin
        nxt_st   = istp_pkg::ST_IDLE;
        nxt_trig = 1'b0;                                          // R13
      end
      default: begin
        nxt_st   = istp_pkg::ST_IDLE;
        nxt_trig = 1'b0;
      end
    endcase
    // operation disable abandons the stop
    if (~nxt_ctrl[`ISTP_CTRL_OPEN]) begin
      nxt_st         = istp_pkg::ST_IDLE;
      nxt_trig       = 1'b0;                                      // R13
      nxt_first_stop = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff         <= istp_pkg::ST_IDLE;
      ctrl_ff       <= `ISTP_CTRL_RST;
      cfg_ff        <= `ISTP_CFG_RST;
      data_ff       <= `ISTP_DATA_RST;
      irq_stat_ff   <= `ISTP_IRQ_RST;
      irq_en_ff     <= `ISTP_IRQ_RST;
      cnt_ff        <= 9'h000;
      trig_ff       <= 1'b0;                                      // R13
      ninth_ff      <= 1'b0;
      first_stop_ff <= 1'b0;
      wrel_ff       <= 1'b0;
      start_ff      <= 1'b0;
      loaded_ff     <= 1'b0;
      sda_q_ff      <= 1'b1;
      prdata_ff     <= 32'h0000_0000;
    end else if (ce_i) begin
      st_ff         <= nxt_st;
      ctrl_ff       <= nxt_ctrl;
      cfg_ff        <= nxt_cfg;
      data_ff       <= nxt_data;
      irq_stat_ff   <= nxt_irq_stat;
      irq_en_ff     <= nxt_irq_en;
      cnt_ff        <= nxt_cnt;
      trig_ff       <= nxt_trig;
      ninth_ff      <= nxt_ninth;
      first_stop_ff <= nxt_first_stop;
      wrel_ff       <= nxt_wrel;
      start_ff      <= nxt_start;
      loaded_ff     <= nxt_loaded;
      sda_q_ff      <= nxt_sda_q;
      prdata_ff     <= nxt_prdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // line drive: enable low means pulling the line low
  assign sda_o    = 1'b0;
  assign scl_o    = 1'b0;
  assign sda_oe_o = ~((st_ff == istp_pkg::ST_SDA_LOW) |                 // R2
                      (st_ff == istp_pkg::ST_SCL_REL) |
                      (st_ff == istp_pkg::ST_HOLD));
  assign scl_oe_o = ~(st_ff == istp_pkg::ST_SDA_LOW);
  assign pready_o = psel_i & penable_i & ce_i & loaded_ff;
  assign pslverr_o = pready_o & ~hit;
  assign prdata_o = prdata_ff;
  assign wait_release_o   = wrel_ff;
  assign start_req_o      = start_ff;
  assign ack_enable_o     = ctrl_ff[`ISTP_CTRL_ACKE];
  assign wait_timing_o    = ctrl_ff[`ISTP_CTRL_WTIM];
  assign reservation_en_o = ~cfg_ff[`ISTP_CFG_RSVDIS];              // R12
  assign stop_busy_o      = trig_ff;
  assign irq_o            = |(irq_stat_ff & irq_en_ff);

endmodule

// >>> testbench/istp_monitor.sv
`timescale 1ns/1ps

// ----------------------------------------
// checker on the stop trigger ports
// ----------------------------------------
module istp_monitor (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        scl_i,
  input  wire logic        scl_oe_o,
  input  wire logic        sda_oe_o,
  input  wire logic        master_i,
  input  wire logic        wait_release_o,
  input  wire logic        reservation_en_o,
  input  wire logic        stop_busy_o
);
  logic        wr_any;
  logic        wr_ctrl;
  logic [2:0]  ln_ff;
  logic [2:0]  nxt_ln;
  logic [11:0] run_ff;
  logic [11:0] nxt_run;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // taken register writes
  assign wr_any = psel_i & penable_i & pwrite_i & pready_o & pstrb_i[0];
  assign wr_ctrl = wr_any & (paddr_i == 12'h000);

  // cycles the line state has stood unchanged
  always_comb begin
    nxt_ln = {scl_oe_o, sda_oe_o, scl_i};
    if (rst_i || nxt_ln != ln_ff) begin
      nxt_run = 12'h000;
    end else begin
      nxt_run = (run_ff == 12'hfff) ? run_ff : run_ff + 12'h001;
    end
  end

  always_ff @(posedge mclk_i) begin
    ln_ff <= nxt_ln;
    run_ff <= nxt_run;
  end

  stop_accept_a:
    assert property (wr_ctrl && pwdata_i[7] && pwdata_i[1:0] == 2'b01
      && master_i && !stop_busy_o |=> stop_busy_o && !sda_oe_o
      && !scl_oe_o && wait_release_o) else $error("stop not started");
  slave_refuse_a:
    assert property (wr_ctrl && !master_i && !stop_busy_o |=> !stop_busy_o)
      else $error("stop taken as slave");
  setup_time_a:
    assert property ($rose(scl_oe_o) && stop_busy_o |->
      run_ff inside {[234:236]}) else $error("clock released early");
  hold_time_a:
    assert property ($rose(sda_oe_o) && stop_busy_o |-> scl_oe_o
      && run_ff inside {[200:206]}) else $error("data released early");
  relock_a:
    assert property (stop_busy_o && wr_ctrl && !pwdata_i[5]
      |=> !wait_release_o) else $error("second stop accepted");
  read_zero_a:
    assert property (psel_i && penable_i && !pwrite_i && pready_o
      && paddr_i == 12'h000 |-> prdata_o[0] == 1'b0)
      else $error("stop bit read as one");
  done_clear_a:
    assert property ($rose(sda_oe_o) && stop_busy_o |=> !stop_busy_o)
      else $error("busy kept after stop");
  off_clear_a:
    assert property (wr_ctrl && !pwdata_i[7] |=> !stop_busy_o)
      else $error("busy kept when disabled");
  rsv_level_a:
    assert property (wr_any && paddr_i == 12'h004 |=>
      reservation_en_o == !$past(pwdata_i[0])) else $error("bad reserve");

  cover property ($rose(stop_busy_o));
  cover property ($rose(sda_oe_o) && stop_busy_o);
  cover property (wr_ctrl && !master_i);
endmodule

bind istp_top istp_monitor u_mon (.*);

// >>> testbench/istp_bus_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// far side: pull-ups, slow slave, other master
// ----------------------------------------
module istp_bus_model (
  input  wire logic mclk_i,
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  input  wire logic slow_i,
  input  wire logic frame_i,
  input  wire logic grab_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic [3:0] str_ff = 4'h0;
  logic [3:0] nxt_str;
  logic       lclk;

  // other master clock, still high outside frames
  initial begin
    lclk = 1'b1;
    #3;
    forever begin
      #80;
      lclk = frame_i ? ~lclk : 1'b1;
    end
  end

  // slow slave stretches the clock after each release
  always_comb begin
    nxt_str = !scl_oe_i ? 4'h0 : (str_ff == 4'hc) ? str_ff : str_ff + 4'h1;
  end

  always_ff @(posedge mclk_i) begin
    str_ff <= nxt_str;
  end

  // wired-and lines with pull-ups
  assign scl_o = scl_oe_i & lclk & (!slow_i | str_ff == 4'hc);
  assign sda_o = sda_oe_i & !grab_i;
endmodule

// >>> testbench/istp_top_tb_top.sv
`timescale 1ns/1ps

// ----------------------------------------
// bench for the stop trigger block
// ----------------------------------------
module istp_top_tb_top;
  logic        clk, rst, psel, pen, pwr, mst, wt, w8, slow, frame, grab;
  logic        prdy, perr, err, scl_oe, sda_oe, scl, sda;
  logic        wrel, sreq, rsv, busy, irq, ack, wtm;
  logic [11:0] paddr;
  logic [31:0] pwd, prd, rd;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;

  istp_top u_dut (
    .mclk_i(clk), .rst_i(rst), .ce_i(1'b1), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .pstrb_i(4'hf),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .scl_i(scl),
    .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .master_i(mst), .wait_i(wt), .wait8_i(w8), .wait_release_o(wrel),
    .start_req_o(sreq), .ack_enable_o(ack), .wait_timing_o(wtm),
    .reservation_en_o(rsv), .stop_busy_o(busy), .irq_o(irq));

  istp_bus_model u_bus (
    .mclk_i(clk), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .slow_i(slow),
    .frame_i(frame), .grab_i(grab), .scl_o(scl), .sda_o(sda));

  // clock and run limit
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, read data left in rd; called just after a rising
  // edge, values read after an edge are those the design sampled at it
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) begin
      @(posedge clk);
    end
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, busy}, 32'h0);
  endtask

  task automatic t_regs();
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h4);
    chk({31'h0, ack}, 32'h1);
    apb(1'b1, 12'h004, 32'h1);
    chk({31'h0, rsv}, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    chk({31'h0, rsv}, 32'h1);
    apb(1'b0, 12'hffc, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("regs test done");
  endtask

  // stop with a second set while busy, then irq raise, mask, clear
  task automatic t_stop(input logic s);
    slow <= s;
    apb(1'b1, 12'h014, 32'h1);
    apb(1'b1, 12'h000, 32'h81);
    chk({30'h0, busy, wrel}, 32'h3);
    chk({31'h0, sda}, 32'h0);
    apb(1'b1, 12'h000, 32'h81);
    chk({31'h0, wrel}, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, s ? 32'hd : 32'h15);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h80);
    wait_idle();
    chk({30'h0, scl, sda}, 32'h3);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd & 32'h5, 32'h5);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h014, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h010, 32'hf);
    apb(1'b1, 12'h014, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("stop test done");
  endtask

  task automatic t_refuse();
    mst <= 1'b0;
    apb(1'b1, 12'h000, 32'h81);
    chk({31'h0, busy}, 32'h0);
    mst <= 1'b1;
    apb(1'b1, 12'h000, 32'h83);
    chk({30'h0, busy, sreq}, 32'h0);
    apb(1'b1, 12'h000, 32'h82);
    chk({31'h0, sreq}, 32'h1);
    apb(1'b1, 12'h000, 32'h80);
    chk({31'h0, busy}, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd & 32'h4, 32'h4);
    apb(1'b1, 12'h000, 32'h81);
    apb(1'b1, 12'h000, 32'h00);
    chk({31'h0, busy}, 32'h0);
    apb(1'b1, 12'h000, 32'h80);
    $display("refuse test done");
  endtask

  // set during a wait after eight clocks, timing select written first
  task automatic t_ninth(input logic [31:0] c, input logic [31:0] e);
    apb(1'b1, 12'h010, 32'hf);
    wt <= 1'b1;
    w8 <= 1'b1;
    apb(1'b1, 12'h000, (c & 32'h8c) | 32'h20);
    chk({29'h0, ack, wtm, wrel}, {29'h0, 1'b0, c[3], 1'b1});
    apb(1'b1, 12'h018, 32'h5a);
    chk({31'h0, wrel}, 32'h1);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h5a);
    apb(1'b1, 12'h000, c);
    wait_idle();
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd & 32'h8, e);
    wt <= 1'b0;
    w8 <= 1'b0;
    $display("ninth test done");
  endtask

  // another master clocks a frame and ends it with its own stop
  task automatic t_busstop();
    apb(1'b1, 12'h010, 32'hf);
    grab <= 1'b1;
    frame <= 1'b1;
    repeat (80) @(posedge clk);
    frame <= 1'b0;
    repeat (20) @(posedge clk);
    grab <= 1'b0;
    repeat (10) @(posedge clk);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd & 32'h2, 32'h2);
    $display("bus stop test done");
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwd = 32'h0;
    mst = 1'b1;
    wt = 1'b0;
    w8 = 1'b0;
    slow = 1'b0;
    frame = 1'b0;
    grab = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_stop(1'b0);
    t_stop(1'b1);
    t_refuse();
    t_ninth(32'h81, 32'h8);
    t_ninth(32'h89, 32'h0);
    t_busstop();
    give_verdict();
  end
endmodule
